// ===== src/qmc_pkg.sv
// How it works
// RULE1: Four coarse mixer bits add +fs/8, +fs/4, +fs/2, -fs/4 shifts.
// RULE2: Gain words are 11-bit unsigned, point between bits 9 and 10, reset unity.
// RULE3: First pair outputs are delayed zero to three cycles, reset zero.
// RULE4: Second pair outputs are delayed zero to three cycles independently, reset zero.
// RULE5: Phase correction words are 12-bit signed fractions from -0.5, reset zero.
// RULE6: First pair phase word times second channel is added to first channel.
// RULE7: Second pair phase word times fourth channel is added to third channel.
// RULE8: First pair gains wait; phase write auto-syncs gains and phase together.
// RULE9: Second pair gain and delay wait; phase write auto-syncs all three together.
// RULE10: Each pair's 16-bit offset adds to accumulator upper 16 bits.
// RULE11: The offset-adjusted 16 bits index the sine and cosine tables.
// RULE12: First pair frequency writes wait; offset write auto-syncs offset and frequency.
// RULE13: Second pair frequency writes wait; offset write auto-syncs all three registers.
// RULE14: Frequency words are 32-bit signed from low and high halves.
// RULE15: PLL reset bit holds the loop filter at zero volts.
// RULE16: Divider-sync enable, set at reset, routes the sync input to N dividers.
// RULE17: PLL enable selects the PLL; cleared by default, the PLL is bypassed.
// RULE18: Charge pump codes: 00 none, 01 single, 11 dual, 10 unused.
// RULE19: Prescaler codes 010 to 111 divide by 2 to 7, 000 by 8.
// RULE20: Read-only loop filter voltage in 0.4125 V steps; aim for 010 to 101.
// RULE21: Each buffered group has a four-bit sync source select, default 0001.
// RULE22: Reserved bits read their defaults; writes to them change nothing.
package qmc_pkg;

  // Register bus request carried as one bundle.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] data;
  } qmc_bus_req_t;

  // Active correction settings of both pairs.
  typedef struct packed {
    logic [3:0]  cmix;
    logic [10:0] gain2;
    logic [10:0] gain3;
    logic [10:0] gain4;
    logic [1:0]  dly1;
    logic [1:0]  dly2;
    logic [11:0] ph1;
    logic [11:0] ph2;
  } qmc_corr_t;

  // Active fine mixer settings of both pairs.
  typedef struct packed {
    logic [15:0] ofs1;
    logic [15:0] ofs2;
    logic [31:0] freq1;
    logic [31:0] freq2;
  } qmc_nco_t;

  localparam int NREG = 13;
  localparam int IDX_CMIXG = 0;
  localparam int IDX_GAIN3 = 1;
  localparam int IDX_DLYG4 = 2;
  localparam int IDX_PH1   = 3;
  localparam int IDX_PH2   = 4;
  localparam int IDX_OFS1  = 5;
  localparam int IDX_OFS2  = 6;
  localparam int IDX_FL1   = 7;
  localparam int IDX_FH1   = 8;
  localparam int IDX_FL2   = 9;
  localparam int IDX_FH2   = 10;
  localparam int IDX_PLL   = 11;
  localparam int IDX_SSEL  = 12;

  localparam logic [7:0] REG_OFF [NREG] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12,
    8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1E};
  localparam logic [7:0] OFF_SOFT_SYNC = 8'h1F;
  localparam logic [15:0] REG_RST [NREG] = '{16'h0400, 16'h0400, 16'h0400, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0808,
    16'h1111};
  localparam logic [15:0] REG_MASK [NREG] = '{16'hF7FF, 16'h07FF, 16'hF7FF, 16'h0FFF,
    16'h0FFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h1CF8,
    16'hFFFF};
  localparam logic [15:0] PLL_FIXED = 16'h2000;

  localparam int PLL_RST_BIT = 12;
  localparam int PLL_NDS_BIT = 11;
  localparam int PLL_ENA_BIT = 10;
  localparam int CP_LSB      = 6;
  localparam int PRE_LSB     = 3;
  localparam int CMIX_LSB    = 12;
  localparam int DLY1_LSB    = 14;
  localparam int DLY2_LSB    = 12;

  localparam int SRC_SOFT = 3;
  localparam int SRC_PIN  = 2;
  localparam int SRC_OSTR = 1;
  localparam int SRC_AUTO = 0;
  localparam int GRP_CORR1 = 3;
  localparam int GRP_CORR2 = 2;
  localparam int GRP_MIX1  = 1;
  localparam int GRP_MIX2  = 0;

  localparam int GAIN_FRAC = 10;
  localparam int PHC_FRAC  = 12;
  localparam logic [2:0] LF_LOW    = 3'h2;
  localparam logic [2:0] LF_HIGH   = 3'h5;
  localparam logic [2:0] PRE_CODE8 = 3'h0;
  localparam logic [3:0] PRE_DIV8  = 4'h8;

endpackage : qmc_pkg

// ===== src/qmc_cfg_bank.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module qmc_cfg_bank (
  input  wire logic               SYS_CLK,
  input  wire logic               NRST,
  input  wire logic [7:0]         ADDR,
  input  wire logic [15:0]        WR_DATA,
  input  wire logic               WR_EN,
  input  wire logic               RD_EN,
  output      logic [15:0]        RD_DATA,
  input  wire logic               SYNC_PIN,
  input  wire logic               OSTR_PIN,
  input  wire logic [2:0]         PLL_LF_VOLT,
  input  wire logic signed [15:0] SAMPLE_A,
  input  wire logic signed [15:0] SAMPLE_B,
  input  wire logic signed [15:0] SAMPLE_C,
  input  wire logic signed [15:0] SAMPLE_D,
  output      logic [15:0]        OUT_A,
  output      logic [15:0]        OUT_B,
  output      logic [15:0]        OUT_C,
  output      logic [15:0]        OUT_D,
  output      logic [15:0]        NCO_AB_INDEX,
  output      logic [15:0]        NCO_CD_INDEX,
  output      logic [2:0]         CMIX_SHIFT,
  output      logic               PLL_LF_HOLD,
  output      logic               PLL_NDIV_SYNC,
  output      logic               PLL_BYPASS,
  output      logic [1:0]         PLL_PUMPS,
  output      logic [3:0]         PLL_PRESCALE,
  output      logic               PLL_LF_IN_RANGE
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // True when the request writes the given offset.
  function automatic logic wr_hit(input qmc_pkg::qmc_bus_req_t r, input logic [7:0] off);
    return r.wr && (r.addr == off);
  endfunction : wr_hit

  // Total coarse shift in fs/8 units, modulo eight; -fs/4 counts as six.
  function automatic logic [2:0] cmix_total(input logic [3:0] m);
    return (m[3] ? 3'h1 : 3'h0) + (m[2] ? 3'h2 : 3'h0)
         + (m[1] ? 3'h4 : 3'h0) + (m[0] ? 3'h6 : 3'h0);
  endfunction : cmix_total

  // Clamp a wide sum to the signed 16-bit sample range.
  function automatic logic signed [15:0] sat16(input logic signed [19:0] v);
    return (v > 20'sh07FFF) ? 16'sh7FFF : ((v < -20'sh08000) ? -16'sh8000 : v[15:0]);
  endfunction : sat16

  // Unsigned gain with ten fraction bits applied to a signed sample.
  function automatic logic signed [19:0] apply_gain(input logic signed [15:0] s,
                                                    input logic [10:0] g);
    logic signed [27:0] p;
    p = s * $signed({1'b0, g});
    return {{2{p[27]}}, p[27:qmc_pkg::GAIN_FRAC]};
  endfunction : apply_gain

  // Signed phase word with twelve fraction bits applied to a signed sample.
  function automatic logic signed [19:0] apply_phase(input logic signed [15:0] s,
                                                     input logic [11:0] ph);
    logic signed [27:0] p;
    p = s * $signed(ph);
    return {{4{p[27]}}, p[27:qmc_pkg::PHC_FRAC]};
  endfunction : apply_phase

  ////////////////////////////////////////////////////////////////////////////////
  // Bus request and programmed registers.

  qmc_pkg::qmc_bus_req_t req;
  logic [15:0]           reg_q [qmc_pkg::NREG];
  logic [15:0]           rd_mux;
  logic [15:0]           rd_data_q;
  logic                  soft_sync;

  // Bundle the plain bus pins into one request.
  assign req       = {WR_EN, RD_EN, ADDR, WR_DATA};
  assign soft_sync = wr_hit(req, qmc_pkg::OFF_SOFT_SYNC);

  // Only writable bits are stored, so reserved bits never steer anything.
  generate
    for (genvar i = 0; i < qmc_pkg::NREG; i++) begin : g_reg
      always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
          reg_q[i] <= qmc_pkg::REG_RST[i];
        end else if (wr_hit(req, qmc_pkg::REG_OFF[i])) begin
          reg_q[i] <= req.data & qmc_pkg::REG_MASK[i]; // RULE22
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and sync event detection.

  logic [2:0] sync_sr_q;
  logic [2:0] ostr_sr_q;
  logic [2:0] lf_meta_q;
  logic [2:0] lf_volt_q;
  logic       sync_rise;
  logic       ostr_rise;

  // Two flops before any use; the third stage only serves the edge detector.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      sync_sr_q <= 3'h0;
      ostr_sr_q <= 3'h0;
      lf_meta_q <= 3'h0;
      lf_volt_q <= 3'h0;
    end else begin
      sync_sr_q <= {sync_sr_q[1:0], SYNC_PIN};
      ostr_sr_q <= {ostr_sr_q[1:0], OSTR_PIN};
      lf_meta_q <= PLL_LF_VOLT;
      lf_volt_q <= lf_meta_q;
    end
  end

  assign sync_rise = sync_sr_q[1] & ~sync_sr_q[2];
  assign ostr_rise = ostr_sr_q[1] & ~ostr_sr_q[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Register read port; data stands only in the cycle after the strobe.

  // The loop filter field is live state, the reserved top of the PLL word reads 001.
  always_comb begin
    rd_mux = 16'h0000;
    for (int i = 0; i < qmc_pkg::NREG; i++) begin
      if (req.addr == qmc_pkg::REG_OFF[i]) begin
        rd_mux = reg_q[i];
      end
    end
    if (req.addr == qmc_pkg::REG_OFF[qmc_pkg::IDX_PLL]) begin
      rd_mux = reg_q[qmc_pkg::IDX_PLL] | qmc_pkg::PLL_FIXED | {13'h0000, lf_volt_q}; // RULE20
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      rd_data_q <= 16'h0000;
    end else begin
      rd_data_q <= req.rd ? rd_mux : 16'h0000; // RULE22
    end
  end

  assign RD_DATA = rd_data_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Sync source selection and double-buffered transfer.

  logic [3:0]         grp_sync;
  logic [3:0]         src_evt;
  qmc_pkg::qmc_corr_t corr_q;
  qmc_pkg::qmc_nco_t  nco_q;

  // Events in source order: software, sync pin, strobe pin, own auto-sync.
  assign src_evt = {soft_sync, sync_rise, ostr_rise, 1'b0};

  // The group-closing write raises the auto-sync; any enabled source may also fire.
  generate
    for (genvar g = 0; g < 4; g++) begin : g_sync
      localparam logic [7:0] CLOSE_OFF = (g == qmc_pkg::GRP_CORR1) ? 8'h10 :
                                         (g == qmc_pkg::GRP_CORR2) ? 8'h11 :
                                         (g == qmc_pkg::GRP_MIX1)  ? 8'h12 : 8'h13;
      logic [3:0] sel;
      assign sel         = reg_q[qmc_pkg::IDX_SSEL][4*g+3 -: 4]; // RULE21
      assign grp_sync[g] = |(sel & (src_evt | {3'h0, wr_hit(req, CLOSE_OFF)}));
    end
  endgenerate

  // The auto-sync write lands in the same cycle, so fresh bus data is forwarded.
  logic [15:0] ph1_new;
  logic [15:0] ph2_new;
  logic [15:0] ofs1_new;
  logic [15:0] ofs2_new;
  assign ph1_new  = wr_hit(req, 8'h10) ? (req.data & 16'h0FFF) : reg_q[qmc_pkg::IDX_PH1];
  assign ph2_new  = wr_hit(req, 8'h11) ? (req.data & 16'h0FFF) : reg_q[qmc_pkg::IDX_PH2];
  assign ofs1_new = wr_hit(req, 8'h12) ? req.data : reg_q[qmc_pkg::IDX_OFS1];
  assign ofs2_new = wr_hit(req, 8'h13) ? req.data : reg_q[qmc_pkg::IDX_OFS2];

  // Both pairs share one process, so the packed correction word has a single driver.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      corr_q.cmix  <= 4'h0;
      corr_q.gain2 <= 11'h400; // RULE2
      corr_q.ph1   <= 12'h000; // RULE5
      corr_q.gain3 <= 11'h400;
      corr_q.gain4 <= 11'h400;
      corr_q.dly1  <= 2'h0; // RULE3
      corr_q.dly2  <= 2'h0; // RULE4
      corr_q.ph2   <= 12'h000;
    end else begin
      if (grp_sync[qmc_pkg::GRP_CORR1]) begin // RULE8
        corr_q.cmix  <= reg_q[qmc_pkg::IDX_CMIXG][qmc_pkg::CMIX_LSB +: 4];
        corr_q.gain2 <= reg_q[qmc_pkg::IDX_CMIXG][10:0];
        corr_q.ph1   <= ph1_new[11:0];
      end
      if (grp_sync[qmc_pkg::GRP_CORR2]) begin // RULE9
      corr_q.gain3 <= reg_q[qmc_pkg::IDX_GAIN3][10:0];
      corr_q.gain4 <= reg_q[qmc_pkg::IDX_DLYG4][10:0];
      corr_q.dly1  <= reg_q[qmc_pkg::IDX_DLYG4][qmc_pkg::DLY1_LSB +: 2];
      corr_q.dly2  <= reg_q[qmc_pkg::IDX_DLYG4][qmc_pkg::DLY2_LSB +: 2];
        corr_q.ph2   <= ph2_new[11:0];
      end
    end
  end

  // Fine mixer words; frequency halves join into one signed step.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      nco_q <= '0;
    end else begin
      if (grp_sync[qmc_pkg::GRP_MIX1]) begin // RULE12
        nco_q.ofs1  <= ofs1_new;
        nco_q.freq1 <= {reg_q[qmc_pkg::IDX_FH1], reg_q[qmc_pkg::IDX_FL1]}; // RULE14
      end
      if (grp_sync[qmc_pkg::GRP_MIX2]) begin // RULE13
        nco_q.ofs2  <= ofs2_new;
        nco_q.freq2 <= {reg_q[qmc_pkg::IDX_FH2], reg_q[qmc_pkg::IDX_FL2]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample correction and pair delay lines.

  logic signed [15:0] corr_s [4];
  logic [15:0]        tap_q  [4][3];
  logic [15:0]        out_q  [4];

  // Phase terms use the raw partner sample, as the current sample of that pair.
  assign corr_s[0] = sat16({{4{SAMPLE_A[15]}}, SAMPLE_A}
                           + apply_phase(SAMPLE_B, corr_q.ph1)); // RULE6
  assign corr_s[1] = sat16(apply_gain(SAMPLE_B, corr_q.gain2));
  assign corr_s[2] = sat16(apply_gain(SAMPLE_C, corr_q.gain3)
                           + apply_phase(SAMPLE_D, corr_q.ph2)); // RULE7
  assign corr_s[3] = sat16(apply_gain(SAMPLE_D, corr_q.gain4));

  // Three taps per channel; the pair delay picks one, zero meaning no tap.
  generate
    for (genvar c = 0; c < 4; c++) begin : g_ch
      logic [1:0] dly;
      assign dly = (c < 2) ? corr_q.dly1 : corr_q.dly2;
      always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
          tap_q[c][0] <= 16'h0000;
          tap_q[c][1] <= 16'h0000;
          tap_q[c][2] <= 16'h0000;
          out_q[c]    <= 16'h0000;
        end else begin
          tap_q[c][0] <= corr_s[c];
          tap_q[c][1] <= tap_q[c][0];
          tap_q[c][2] <= tap_q[c][1];
          out_q[c]    <= (dly == 2'h0) ? corr_s[c] : tap_q[c][dly - 2'h1]; // RULE3 RULE4
        end
      end
    end
  endgenerate

  assign OUT_A = out_q[0];
  assign OUT_B = out_q[1];
  assign OUT_C = out_q[2];
  assign OUT_D = out_q[3];

  ////////////////////////////////////////////////////////////////////////////////
  // Phase accumulators and table index.

  logic [31:0] acc1_q;
  logic [31:0] acc2_q;
  logic [15:0] idx1_q;
  logic [15:0] idx2_q;

  // The offset shifts only the top half; the wrap of the sum is intended.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      acc1_q <= 32'h00000000;
      acc2_q <= 32'h00000000;
      idx1_q <= 16'h0000;
      idx2_q <= 16'h0000;
    end else begin
      acc1_q <= acc1_q + nco_q.freq1; // RULE14
      acc2_q <= acc2_q + nco_q.freq2;
      idx1_q <= acc1_q[31:16] + nco_q.ofs1; // RULE10 RULE11
      idx2_q <= acc2_q[31:16] + nco_q.ofs2;
    end
  end

  assign NCO_AB_INDEX = idx1_q;
  assign NCO_CD_INDEX = idx2_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Coarse mixer and PLL controls.

  logic [15:0] pll_w;
  logic [2:0]  pre_code;
  logic [1:0]  cp_code;
  logic [2:0]  cmix_q;
  logic        lf_hold_q;
  logic        ndiv_sync_q;
  logic        bypass_q;
  logic [1:0]  pumps_q;
  logic [3:0]  prescale_q;
  logic        lf_ok_q;

  assign pll_w    = reg_q[qmc_pkg::IDX_PLL];
  assign pre_code = pll_w[qmc_pkg::PRE_LSB +: 3];
  assign cp_code  = pll_w[qmc_pkg::CP_LSB +: 2];

  // PLL controls act at once; they are not part of any buffered group.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      cmix_q      <= 3'h0;
      lf_hold_q   <= 1'b0;
      ndiv_sync_q <= 1'b0;
      bypass_q    <= 1'b1;
      pumps_q     <= 2'h0;
      prescale_q  <= 4'h1;
      lf_ok_q     <= 1'b0;
    end else begin
      cmix_q      <= cmix_total(corr_q.cmix); // RULE1
      lf_hold_q   <= pll_w[qmc_pkg::PLL_RST_BIT]; // RULE15
      ndiv_sync_q <= pll_w[qmc_pkg::PLL_NDS_BIT] & sync_sr_q[1]; // RULE16
      bypass_q    <= ~pll_w[qmc_pkg::PLL_ENA_BIT]; // RULE17
      pumps_q     <= (cp_code == 2'h3) ? 2'h2 : ((cp_code == 2'h1) ? 2'h1 : 2'h0); // RULE18
      prescale_q  <= (pre_code == qmc_pkg::PRE_CODE8) ? qmc_pkg::PRE_DIV8
                                                      : {1'b0, pre_code}; // RULE19
      lf_ok_q     <= (lf_volt_q >= qmc_pkg::LF_LOW) && (lf_volt_q <= qmc_pkg::LF_HIGH); // RULE20
    end
  end

  assign CMIX_SHIFT      = cmix_q;
  assign PLL_LF_HOLD     = lf_hold_q;
  assign PLL_NDIV_SYNC   = ndiv_sync_q;
  assign PLL_BYPASS      = bypass_q;
  assign PLL_PUMPS       = pumps_q;
  assign PLL_PRESCALE    = prescale_q;
  assign PLL_LF_IN_RANGE = lf_ok_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  AST_CMIX_SUM: assert property ( // RULE1
    corr_q.cmix == 4'hC |=> CMIX_SHIFT == 3'h3)
    else $error("Coarse shift is not the sum of enabled mixers.");
  AST_DELAY_THREE: assert property ( // RULE3
    (corr_q.dly1 == 2'h3) [*5] |-> OUT_A == $past(corr_s[0], 4))
    else $error("First pair delay of three is wrong.");
  AST_DELAY_ZERO: assert property ( // RULE4
    (corr_q.dly2 == 2'h0) [*2] |-> OUT_C == $past(corr_s[2]))
    else $error("Second pair delay of zero is wrong.");
  AST_GAIN_WAIT: assert property ( // RULE9
    wr_hit(req, 8'h0E) && !grp_sync[qmc_pkg::GRP_CORR2] |=> $stable(corr_q.gain3))
    else $error("Gain write changed active correction without sync.");
  AST_PH1_AUTO: assert property ( // RULE8
    wr_hit(req, 8'h10) && reg_q[qmc_pkg::IDX_SSEL][12]
    |=> corr_q.ph1 == $past(req.data[11:0])
        && corr_q.gain2 == $past(reg_q[qmc_pkg::IDX_CMIXG][10:0]))
    else $error("First pair auto-sync did not apply gain and phase.");
  AST_FREQ_WAIT: assert property ( // RULE12
    wr_hit(req, 8'h14) && !grp_sync[qmc_pkg::GRP_MIX1] |=> $stable(nco_q.freq1))
    else $error("Frequency write changed the mixer without sync.");
  AST_OFS2_AUTO: assert property ( // RULE13
    wr_hit(req, 8'h13) && reg_q[qmc_pkg::IDX_SSEL][0]
    |=> nco_q.ofs2 == $past(req.data)
        && nco_q.freq2 == {$past(reg_q[qmc_pkg::IDX_FH2]), $past(reg_q[qmc_pkg::IDX_FL2])})
    else $error("Second pair auto-sync did not apply offset and frequency.");
  AST_INDEX: assert property ( // RULE10
    ##2 NCO_AB_INDEX == $past(acc1_q[31:16]) + $past(nco_q.ofs1))
    else $error("Table index is not accumulator plus offset.");
  AST_LF_HOLD: assert property ( // RULE15
    wr_hit(req, 8'h18) && req.data[qmc_pkg::PLL_RST_BIT] |=> ##2 PLL_LF_HOLD)
    else $error("PLL reset bit did not hold the loop filter.");
  AST_BYPASS: assert property ( // RULE17
    !pll_w[qmc_pkg::PLL_ENA_BIT] |=> PLL_BYPASS)
    else $error("Cleared PLL enable did not bypass.");
  AST_PUMP_UNUSED: assert property ( // RULE18
    cp_code == 2'h2 |=> PLL_PUMPS == 2'h0)
    else $error("Unused pump code drove a pump.");
  AST_PRESCALE: assert property ( // RULE19
    pre_code == 3'h0 |=> PLL_PRESCALE == 4'h8)
    else $error("Prescaler code zero did not select eight.");
  AST_RESERVED: assert property ( // RULE22
    req.rd && req.addr == 8'h18 |=> RD_DATA[15:13] == 3'h1 && RD_DATA[9:8] == 2'h0)
    else $error("Reserved PLL bits read wrong.");

  CVR_CORR1_SYNC: cover property (wr_hit(req, 8'h10) ##1 corr_q.ph1 != 12'h000);
  CVR_MIX2_SYNC:  cover property (grp_sync[qmc_pkg::GRP_MIX2] ##1 nco_q.freq2 != 32'h0);
  CVR_PIN_SYNC:   cover property (sync_rise && grp_sync != 4'h0);
  CVR_DELAY3:     cover property ((corr_q.dly1 == 2'h3) [*5]);

endmodule : qmc_cfg_bank

// ===== verification/qmc_cfg_bank_tb.sv
`timescale 1ns/1ns
module qmc_cfg_bank_tb;
  logic        sys_clk, nrst, wr_en, rd_en, sync_pin, lf_hold, ndiv, bypass, in_range, ostr_pin;
  logic [7:0]  addr;
  logic [15:0] wr_data, rd_data, smp_a, smp_b, smp_c, smp_d;
  logic [15:0] out_a, out_b, out_c, out_d, idx_ab, idx_cd;
  logic [2:0]  lf_volt, cmix;
  logic [1:0]  pumps;
  logic [3:0]  prescale;
  int          bad_count, n_tests, cyc;

  qmc_cfg_bank DUT (.SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr), .WR_DATA(wr_data),
    .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .SYNC_PIN(sync_pin), .OSTR_PIN(ostr_pin),
    .PLL_LF_VOLT(lf_volt), .SAMPLE_A(smp_a), .SAMPLE_B(smp_b), .SAMPLE_C(smp_c),
    .SAMPLE_D(smp_d), .OUT_A(out_a), .OUT_B(out_b), .OUT_C(out_c), .OUT_D(out_d),
    .NCO_AB_INDEX(idx_ab), .NCO_CD_INDEX(idx_cd), .CMIX_SHIFT(cmix), .PLL_LF_HOLD(lf_hold),
    .PLL_NDIV_SYNC(ndiv), .PLL_BYPASS(bypass), .PLL_PUMPS(pumps), .PLL_PRESCALE(prescale),
    .PLL_LF_IN_RANGE(in_range));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling, so a stuck run still ends with a verdict.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus tasks: every call starts on the next edge, so strobes never overlap.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdchk

  // Waits n edges and lets their updates settle before anything is sampled.
  task automatic pause(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : pause

  task automatic stop_test();
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {nrst, wr_en, rd_en, sync_pin, ostr_pin, addr, wr_data, bad_count, n_tests, cyc} = '0;
    lf_volt = 3'h3;
    smp_a = 16'h1000;
    smp_b = 16'h0800;
    smp_c = 16'h1000;
    smp_d = 16'h0800;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset values of the bank, then an unmapped place and reserved bits.
    for (int a = 8'h0D; a <= 8'h17; a++) begin
      rdchk(8'(a), (a <= 8'h0F) ? 16'h0400 : 16'h0000);
    end
    rdchk(8'h18, 16'h2808 | 16'h0003);
    rdchk(8'h1E, 16'h1111);
    rdchk(8'h20, 16'h0000);
    wr(8'h0E, 16'hFFFF);
    rdchk(8'h0E, 16'h07FF);
    wr(8'h0E, 16'h0400);
    // First pair: staged gain and mixer mode wait for the phase write.
    wr(8'h0D, 16'hC200);
    pause(4);
    chk(out_b, 16'h0800);
    chk({13'h0, cmix}, 16'h0000);
    wr(8'h10, 16'h0400);
    pause(4);
    chk(out_a, 16'h1200);
    chk(out_b, 16'h0400);
    chk({13'h0, cmix}, 16'h0003);
    // Second pair: negative phase, half gain on D and a three-cycle delay.
    // Both pairs get a three-cycle delay; a step on A and C shows it.
    wr(8'h0F, 16'hF200);
    pause(4);
    chk(out_d, 16'h0800);
    wr(8'h11, 16'h0C00);
    pause(6);
    chk(out_c, 16'h0E00);
    chk(out_d, 16'h0400);
    @(posedge sys_clk);
    smp_a <= 16'h2000;
    smp_c <= 16'h2000;
    pause(3);
    chk(out_c, 16'h0E00);
    chk(out_a, 16'h1200);
    pause(1);
    chk(out_c, 16'h1E00);
    chk(out_a, 16'h2200);
    // Fine mixers: frequency waits for the offset write; offset adds to index.
    wr(8'h15, 16'h0001);
    pause(3);
    chk(idx_ab, 16'h0000);
    wr(8'h12, 16'h0100);
    pause(3);
    chk(idx_ab, 16'h0102);
    pause(1);
    chk(idx_ab, 16'h0103);
    wr(8'h13, 16'hABCD);
    pause(3);
    chk(idx_cd, 16'hABCD);
    // Soft sync, then a strobe pin edge, load the second mixer when selected.
    wr(8'h1E, 16'h111B);
    wr(8'h17, 16'h0001);
    wr(8'h1F, 16'h0000);
    pause(3);
    chk(idx_cd, 16'hABCF);
    wr(8'h17, 16'h0000);
    @(posedge sys_clk);
    ostr_pin <= 1'b1;
    pause(6);
    chk(idx_cd, 16'hABD6);
    // PLL controls in several settings, with the divider sync gate.
    @(posedge sys_clk);
    sync_pin <= 1'b1;
    pause(5);
    chk({15'h0, ndiv}, 16'h0001);
    wr(8'h18, 16'h14C0);
    pause(3);
    chk({12'h0, lf_hold, bypass, pumps}, 16'h000A);
    chk({12'h0, prescale}, 16'h0008);
    chk({15'h0, ndiv}, 16'h0000);
    rdchk(8'h18, 16'h34C3);
    wr(8'h18, 16'h0868);
    pause(3);
    chk({12'h0, lf_hold, bypass, pumps}, 16'h0005);
    chk({12'h0, prescale}, 16'h0005);
    wr(8'h18, 16'h0880);
    pause(3);
    chk({12'h0, lf_hold, bypass, pumps}, 16'h0004);
    chk({12'h0, prescale}, 16'h0008);
    // Loop filter reading against the preferred band.
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk);
      lf_volt <= 3'(k);
      pause(5);
      chk({15'h0, in_range}, (k >= 2 && k <= 5) ? 16'h0001 : 16'h0000);
    end
    stop_test();
  end
endmodule : qmc_cfg_bank_tb
